// ### core/cspa_pin_slot.sv
/*
  One pin of the chip-select pin multiplexer: picks the level the pin
  carries from its function field.
  Assumes the caller registers the result; purely combinational.
*/
`timescale 1ns/1ps
module cspa_pin_slot
  import cspa_pkg::*;
(
  // function selection
  input wire logic [1:0] field_in,
  input wire logic is_boot_in,
  // candidate pin levels
  input wire logic cs_n_in,
  input wire logic alt_in,
  input wire logic disc_in,
  // selected behaviour
  output logic level_out,
  output logic is_cs_out,
  output logic is_16bit_out
);

  // field decode; the boot pin is always a chip-select
  always_comb
  begin
    level_out = cs_n_in;
    is_cs_out = 1'b1;
    is_16bit_out = field_in[0];
    if (!is_boot_in)
    begin
      unique case (field_in)
        FUNC_DISCRETE:
        begin
          level_out = disc_in;
          is_cs_out = 1'b0;
          is_16bit_out = 1'b0;
        end
        FUNC_ALTERNATE:
        begin
          level_out = alt_in;
          is_cs_out = 1'b0;
          is_16bit_out = 1'b0;
        end
        FUNC_CS_8BIT:
        begin
          level_out = cs_n_in;
          is_16bit_out = 1'b0;
        end
        FUNC_CS_16BIT:
        begin
          level_out = cs_n_in;
          is_16bit_out = 1'b1;
        end
      endcase
    end
  end

endmodule : cspa_pin_slot

// ### core/cspa_pkg.sv
/*
  Shared constants for the chip-select pin assignment block: register
  offsets, field positions, field encodings and reset values.
  Assumes a 16-bit register port addressed by byte offset.
*/
package cspa_pkg;

  // register port geometry
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 16;

  // byte offsets of the three registers
  localparam logic [7:0] OFS_PORT_C_OUTPUT_LATCH = 8'h40;
  localparam logic [7:0] OFS_CHIP_SELECT_PIN_ASSIGN_LOW = 8'h44;
  localparam logic [7:0] OFS_CHIP_SELECT_PIN_ASSIGN_HIGH = 8'h46;

  // pin count: boot select plus chip-selects 0 to 10
  localparam int unsigned NUM_PINS = 12;
  localparam int unsigned NUM_LOW_FIELDS = 7;
  localparam int unsigned NUM_HIGH_FIELDS = 5;
  localparam int unsigned FIELD_W = 2;

  // implemented widths of each register
  localparam int unsigned PORT_BITS = 7;
  localparam int unsigned LOW_BITS = 14;
  localparam int unsigned HIGH_BITS = 10;

  // pin index of the boot select, of cs0, of the first high-order select and of cs10
  localparam int unsigned PIN_BOOT = 0;
  localparam int unsigned PIN_CS0 = 1;
  localparam int unsigned PIN_CS6 = 7;
  localparam int unsigned PIN_CS10 = 11;

  // fixed bit of the boot field
  localparam int unsigned BOOT_FIXED_BIT = 1;

  // encodings of a pin function field
  localparam logic [1:0] FUNC_DISCRETE = 2'h0;
  localparam logic [1:0] FUNC_ALTERNATE = 2'h1;
  localparam logic [1:0] FUNC_CS_8BIT = 2'h2;
  localparam logic [1:0] FUNC_CS_16BIT = 2'h3;

  // reset value of the port latch
  localparam logic [6:0] PORT_C_RESET = 7'h7f;

  // chip-select outputs idle high (active low)
  localparam logic PIN_IDLE = 1'b1;

endpackage : cspa_pkg

// ### core/cspa_top.sv
/*
  Chip-select pin assignment block: port C output latch, two pin
  assignment registers and the pin multiplexer for the boot select and
  chip-selects 0 to 10.
  Assumes synchronous inputs on clk_in, a register master that never
  waits, and that data_strap_in carries the data bus during reset.
*/
`timescale 1ns/1ps
module cspa_top
  import cspa_pkg::*;
#(
  parameter int unsigned REG_DATA_W = DATA_W
)
(
  // clock and reset
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // register port
  input wire logic [cspa_pkg::ADDR_W-1:0] reg_addr_in,
  input wire logic [cspa_pkg::DATA_W-1:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [cspa_pkg::DATA_W-1:0] reg_rdata_out,
  // data bus level sampled during reset
  input wire logic [7:0] data_strap_in,
  // chip-select decodes, active low, index 0 boot, 1 to 11 cs0 to cs10
  input wire logic [cspa_pkg::NUM_PINS-1:0] cs_assert_n_in,
  // alternate function sources, and the cs10 discrete source
  input wire logic function_code_bit2_in,
  input wire logic function_code_bit1_in,
  input wire logic function_code_bit0_in,
  input wire logic grant_acknowledge_in,
  input wire logic bus_grant_in,
  input wire logic bus_request_in,
  input wire logic addr_line19_in,
  input wire logic e_clock_output_in,
  // pin levels and their configuration
  output logic [cspa_pkg::NUM_PINS-1:0] pin_level_out,
  output logic [cspa_pkg::NUM_PINS-1:0] pin_is_cs_out,
  output logic [cspa_pkg::NUM_PINS-1:0] pin_is_16bit_out
);

  import cspa_pkg::*;

  // elaboration check: the register map is 16 bits wide
  if (REG_DATA_W != DATA_W)
  begin : g_bad_width
    $error("cspa_top: REG_DATA_W must equal 16");
  end

  // every pin needs exactly one function field
  if (NUM_LOW_FIELDS + NUM_HIGH_FIELDS != NUM_PINS)
  begin : g_bad_pins
    $error("cspa_top: field count must match pin count");
  end

  // register images are the fields packed back to back
  if (LOW_BITS != FIELD_W*NUM_LOW_FIELDS || HIGH_BITS != FIELD_W*NUM_HIGH_FIELDS)
  begin : g_bad_fields
    $error("cspa_top: register widths must match the field counts");
  end

  // read path zero-extends, so no image may exceed the data word
  if (PORT_BITS > DATA_W || LOW_BITS > DATA_W || HIGH_BITS > DATA_W)
  begin : g_bad_regs
    $error("cspa_top: register image wider than the data word");
  end

  // whole state of the block
  typedef struct packed {
    logic [PORT_BITS-1:0] port_c_output_latch;
    logic [LOW_BITS-1:0] chip_select_pin_assign_low;
    logic [HIGH_BITS-1:0] chip_select_pin_assign_high;
    logic [DATA_W-1:0] rdata;
    logic [NUM_PINS-1:0] level;
    logic [NUM_PINS-1:0] is_cs;
    logic [NUM_PINS-1:0] is_16bit;
  } cspa_state_t;

  cspa_state_t state;
  cspa_state_t next_state;

  // per-pin field, sources and slot results
  logic [FIELD_W-1:0] pin_function_field [NUM_PINS];
  logic [NUM_PINS-1:0] alt_src;
  logic [NUM_PINS-1:0] disc_src;
  logic [NUM_PINS-1:0] slot_level;
  logic [NUM_PINS-1:0] slot_is_cs;
  logic [NUM_PINS-1:0] slot_is_16bit;
  logic [FIELD_W-1:0] boot_select_function_field;

  // reset images built from the straps
  logic [LOW_BITS-1:0] low_reset;
  logic [HIGH_BITS-1:0] high_reset;
  logic straps_high;

  // address decode
  logic hit_port;
  logic hit_low;
  logic hit_high;

  assign hit_port = (reg_addr_in == OFS_PORT_C_OUTPUT_LATCH);
  assign hit_low = (reg_addr_in == OFS_CHIP_SELECT_PIN_ASSIGN_LOW);
  assign hit_high = (reg_addr_in == OFS_CHIP_SELECT_PIN_ASSIGN_HIGH);

  // low register reset image: fc fields from data 2, bus fields from data 1
  assign low_reset = {
    data_strap_in[2], 1'b1,
    data_strap_in[2], 1'b1,
    data_strap_in[2], 1'b1,
    data_strap_in[1], 1'b1,
    data_strap_in[1], 1'b1,
    data_strap_in[1], 1'b1,
    1'b1, data_strap_in[0]
  };

  // high register reset image: a select only if every higher strap is high
  always_comb
  begin
    high_reset = '0;
    straps_high = 1'b1;
    // walk down from data 7 so each field sees all straps above it
    for (int k = NUM_HIGH_FIELDS - 1; k >= 0; k--)
    begin
      straps_high = straps_high & data_strap_in[3+k];
      high_reset[2*k+1] = straps_high;
      high_reset[2*k] = 1'b1;
    end
  end

  // split the registers into one field per pin
  always_comb
  begin
    pin_function_field[PIN_BOOT] = state.chip_select_pin_assign_low[1:0];
    for (int k = 0; k < NUM_LOW_FIELDS - 1; k++)
    begin
      pin_function_field[PIN_CS0+k] =
        state.chip_select_pin_assign_low[2*k+2 +: 2];
    end
    for (int k = 0; k < NUM_HIGH_FIELDS; k++)
    begin
      pin_function_field[PIN_CS6+k] =
        state.chip_select_pin_assign_high[2*k +: 2];
    end
  end

  assign boot_select_function_field = pin_function_field[PIN_BOOT];

  // alternate sources: bus arbitration, function codes, high address lines
  always_comb
  begin
    alt_src = '0;
    alt_src[PIN_CS0] = bus_request_in;
    alt_src[PIN_CS0+1] = bus_grant_in;
    alt_src[PIN_CS0+2] = grant_acknowledge_in;
    alt_src[PIN_CS0+3] = function_code_bit0_in;
    alt_src[PIN_CS0+4] = function_code_bit1_in;
    alt_src[PIN_CS0+5] = function_code_bit2_in;
    // upper address lines mirror line 19 since no wider address exists
    for (int k = 0; k < NUM_HIGH_FIELDS; k++)
    begin
      alt_src[PIN_CS6+k] = addr_line19_in;
    end
  end

  // discrete sources; cs2-cs0 have no port bit and idle high
  always_comb
  begin
    disc_src = {NUM_PINS{PIN_IDLE}};
    disc_src[PIN_CS0+3] = state.port_c_output_latch[0];
    disc_src[PIN_CS0+4] = state.port_c_output_latch[1];
    disc_src[PIN_CS0+5] = state.port_c_output_latch[2];
    for (int k = 0; k < 4; k++)
    begin
      disc_src[PIN_CS6+k] = state.port_c_output_latch[3+k];
    end
    disc_src[PIN_CS10] = e_clock_output_in;
  end

  // one multiplexer slot per pin
  for (genvar i = 0; i < NUM_PINS; i++)
  begin : g_slot
    cspa_pin_slot u_slot (
      .field_in(pin_function_field[i]),
      .is_boot_in(i == PIN_BOOT),
      .cs_n_in(cs_assert_n_in[i]),
      .alt_in(alt_src[i]),
      .disc_in(disc_src[i]),
      .level_out(slot_level[i]),
      .is_cs_out(slot_is_cs[i]),
      .is_16bit_out(slot_is_16bit[i])
    );
  end

  // next state: reset straps, register writes, read capture, pin outputs
  always_comb
  begin
    next_state = state;
    next_state.rdata = '0;
    // pins registered so every output comes from a flip-flop
    next_state.level = slot_level;
    next_state.is_cs = slot_is_cs;
    next_state.is_16bit = slot_is_16bit;
    if (reg_wr_in)
    begin
      // writes accepted outside reset, unmapped offsets ignored
      if (hit_port)
      begin
        next_state.port_c_output_latch = reg_wdata_in[PORT_BITS-1:0];
      end
      if (hit_low)
      begin
        next_state.chip_select_pin_assign_low = reg_wdata_in[LOW_BITS-1:0];
        next_state.chip_select_pin_assign_low[BOOT_FIXED_BIT] = 1'b1;
      end
      if (hit_high)
      begin
        next_state.chip_select_pin_assign_high = reg_wdata_in[HIGH_BITS-1:0];
      end
    end
    if (reg_rd_in)
    begin
      // unimplemented upper bits and unmapped offsets read zero
      if (hit_port)
      begin
        next_state.rdata = {{(DATA_W-PORT_BITS){1'b0}}, state.port_c_output_latch};
      end
      if (hit_low)
      begin
        next_state.rdata = {{(DATA_W-LOW_BITS){1'b0}}, state.chip_select_pin_assign_low};
      end
      if (hit_high)
      begin
        next_state.rdata = {{(DATA_W-HIGH_BITS){1'b0}}, state.chip_select_pin_assign_high};
      end
    end
    if (sys_rst_in)
    begin
      // synchronous reset, so the straps may be sampled directly
      next_state.port_c_output_latch = PORT_C_RESET;
      next_state.chip_select_pin_assign_low = low_reset;
      next_state.chip_select_pin_assign_high = high_reset;
      next_state.rdata = '0;
      next_state.level = {NUM_PINS{PIN_IDLE}};
      next_state.is_cs = '0;
      next_state.is_16bit = '0;
    end
  end

  // single state register
  always_ff @(posedge clk_in)
  begin
    state <= next_state;
  end

  // outputs straight from the state flops
  assign reg_rdata_out = state.rdata;
  assign pin_level_out = state.level;
  assign pin_is_cs_out = state.is_cs;
  assign pin_is_16bit_out = state.is_16bit;

endmodule : cspa_top

// ### tb/cspa_ext_dev.sv
/*
  External device on one chip-select pin: counts selected cycles.
  Assumes an active-low select, meaningful only in a select mode.
*/
`timescale 1ns/1ps
module cspa_ext_dev
(
  // clock, reset and pin
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic sel_n_in,
  input wire logic is_cs_in,
  // selected cycles seen
  output logic [7:0] sel_cycles_out
);
  // a pin in another mode is no select, so it must not count
  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
      sel_cycles_out <= 8'h0;
    else if (is_cs_in && !sel_n_in)
      sel_cycles_out <= sel_cycles_out + 8'h1;
  end
endmodule : cspa_ext_dev

// ### tb/cspa_top_asserts.sv
/*
  Checker for cspa_top: register read framing and pin relations.
  Assumes it is bound to cspa_top and sees only its ports.
*/
`timescale 1ns/1ps
module cspa_top_asserts
  import cspa_pkg::*;
(
  // watched ports
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic [cspa_pkg::ADDR_W-1:0] reg_addr_in,
  input wire logic reg_rd_in,
  input wire logic [cspa_pkg::DATA_W-1:0] reg_rdata_out,
  input wire logic [cspa_pkg::NUM_PINS-1:0] cs_assert_n_in,
  input wire logic [cspa_pkg::NUM_PINS-1:0] pin_level_out,
  input wire logic [cspa_pkg::NUM_PINS-1:0] pin_is_cs_out,
  input wire logic [cspa_pkg::NUM_PINS-1:0] pin_is_16bit_out
);
  default clocking dc @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  // read data only in the cycle after a read strobe
  rdata_idle_a: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 16'h0)
    else $error("read data outside read cycle");
  low_top_a: assert property ($past(reg_rd_in) && $past(reg_addr_in) ==
    OFS_CHIP_SELECT_PIN_ASSIGN_LOW |-> reg_rdata_out[15:14] == 2'h0)
    else $error("low register top bits not zero");
  boot_bit_a: assert property ($past(reg_rd_in) && $past(reg_addr_in) ==
    OFS_CHIP_SELECT_PIN_ASSIGN_LOW |-> reg_rdata_out[1])
    else $error("boot field upper bit not one");
  high_top_a: assert property ($past(reg_rd_in) && $past(reg_addr_in) ==
    OFS_CHIP_SELECT_PIN_ASSIGN_HIGH |-> reg_rdata_out[15:10] == 6'h0)
    else $error("high register top bits not zero");
  port_top_a: assert property ($past(reg_rd_in) && $past(reg_addr_in) ==
    OFS_PORT_C_OUTPUT_LATCH |-> reg_rdata_out[15:7] == 9'h0)
    else $error("port latch top bits not zero");
  // outputs lag release by one edge; the check looks back two
  boot_cs_a: assert property (!$past(sys_rst_in, 2) && !$past(sys_rst_in)
    |-> pin_is_cs_out[0])
    else $error("boot pin not a select");
  cs_follow_a: assert property ((pin_is_cs_out &
    (pin_level_out ^ $past(cs_assert_n_in))) == 12'h0)
    else $error("select pin not following its decode");
  wide_cs_a: assert property ((pin_is_16bit_out & ~pin_is_cs_out) == 12'h0)
    else $error("wide flag on a non-select pin");
  cover property (pin_is_16bit_out[5]);
  cover property (pin_is_cs_out[5] && !pin_level_out[5]);
  cover property ($past(reg_rd_in) && reg_rdata_out != 16'h0);
endmodule : cspa_top_asserts

bind cspa_top cspa_top_asserts u_chk (.clk_in, .sys_rst_in, .reg_addr_in, .reg_rd_in,
  .reg_rdata_out, .cs_assert_n_in, .pin_level_out, .pin_is_cs_out, .pin_is_16bit_out);

// ### tb/cspa_top_tb.sv
/*
  Testbench for cspa_top: reset straps, register access, pin modes.
  Assumes the checker is bound in and the device model sits on pin 5.
*/
`timescale 1ns/1ps
module cspa_top_tb;
  import cspa_pkg::*;
  logic clk_in, sys_rst_in, reg_wr_in, reg_rd_in;
  logic [7:0] reg_addr_in, data_strap_in, src, cnt, c0;
  logic [15:0] reg_wdata_in, reg_rdata_out, lo, hi;
  logic [11:0] cs_n, lv, iscs, is16;
  int mismatches, comparisons;
  logic [7:0] straps [4] = '{8'hff, 8'h00, 8'hd6, 8'hf9};

  always #10 clk_in = ~clk_in;

  cspa_top u_dut (.clk_in, .sys_rst_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in,
    .reg_rd_in, .reg_rdata_out, .data_strap_in, .cs_assert_n_in(cs_n),
    .function_code_bit2_in(src[5]), .function_code_bit1_in(src[4]),
    .function_code_bit0_in(src[3]), .grant_acknowledge_in(src[2]),
    .bus_grant_in(src[1]), .bus_request_in(src[0]), .addr_line19_in(src[6]),
    .e_clock_output_in(src[7]), .pin_level_out(lv), .pin_is_cs_out(iscs),
    .pin_is_16bit_out(is16));
  cspa_ext_dev u_dev (.clk_in, .sys_rst_in, .sel_n_in(lv[5]), .is_cs_in(iscs[5]),
    .sel_cycles_out(cnt));

  task stop_test;
    $display("checks %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : stop_test

  task chk(input string n, input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e)
    begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  // strobe is dropped and an edge passes before the next request
  task wr(input logic [7:0] a, input logic [15:0] d);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge clk_in);
    reg_wr_in <= 1'b0;
    @(posedge clk_in);
  endtask : wr

  task rd(input logic [7:0] a, input logic [15:0] e, input string n);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge clk_in);
    reg_rd_in <= 1'b0;
    #1 chk(n, e, reg_rdata_out);
    @(posedge clk_in);
  endtask : rd

  function automatic logic [15:0] hi_rst(input logic [7:0] d);
    logic [15:0] h;
    logic a;
    h = 16'h0;
    a = 1'b1;
    for (int k = 4; k >= 0; k--)
    begin
      a = a & d[3+k];
      h[2*k+:2] = {a, 1'b1};
    end
    return h;
  endfunction : hi_rst

  // expected {level, is select, is wide} of pin i under field f
  function automatic logic [2:0] pin_exp(input int i, input logic [1:0] f,
    input logic [6:0] p);
    logic v;
    if (i == 0 || f[1])
      v = cs_n[i];
    else if (f[0])
      v = src[i < 7 ? i - 1 : 6];
    else if (i == 11)
      v = src[7];
    else
      v = (i < 4) ? 1'b1 : p[i-4];
    return {v, i == 0 || f[1], i == 0 ? f[0] : f == 2'h3};
  endfunction : pin_exp

  task pins(input logic [15:0] l, input logic [15:0] h, input logic [15:0] p);
    logic [23:0] f;
    logic [11:0] el, ec, e16;
    f = {h[9:0], l[13:0]};
    repeat (2) @(posedge clk_in);
    #1;
    for (int i = 0; i < 12; i++)
      {el[i], ec[i], e16[i]} = pin_exp(i, f[2*i+:2], p[6:0]);
    chk("pin level", {4'h0, el}, {4'h0, lv});
    chk("pin select", {4'h0, ec}, {4'h0, iscs});
    chk("pin wide", {4'h0, e16}, {4'h0, is16});
    @(posedge clk_in);
  endtask : pins

  // hang guard
  initial
  begin
    #200000;
    mismatches++;
    stop_test();
  end

  initial
  begin
    clk_in = 1'b0;
    sys_rst_in = 1'b1;
    {reg_wr_in, reg_rd_in, reg_addr_in, reg_wdata_in, data_strap_in, src} = '0;
    cs_n = 12'hfff;
    foreach (straps[j])
    begin
      data_strap_in <= straps[j];
      sys_rst_in <= 1'b1;
      repeat (8) @(posedge clk_in);
      sys_rst_in <= 1'b0;
      @(posedge clk_in);
      lo = {2'h0, {3{straps[j][2], 1'b1}}, {3{straps[j][1], 1'b1}}, 1'b1, straps[j][0]};
      rd(OFS_PORT_C_OUTPUT_LATCH, 16'h007f, "port reset");
      rd(OFS_CHIP_SELECT_PIN_ASSIGN_LOW, lo, "low reset");
      rd(OFS_CHIP_SELECT_PIN_ASSIGN_HIGH, hi_rst(straps[j]), "high reset");
      pins(lo, hi_rst(straps[j]), 16'h007f);
    end
    $display("test reset values done");
    wr(OFS_CHIP_SELECT_PIN_ASSIGN_LOW, 16'hffff);
    rd(OFS_CHIP_SELECT_PIN_ASSIGN_LOW, 16'h3fff, "low ones");
    wr(OFS_CHIP_SELECT_PIN_ASSIGN_LOW, 16'h0000);
    rd(OFS_CHIP_SELECT_PIN_ASSIGN_LOW, 16'h0002, "low zeros");
    wr(OFS_CHIP_SELECT_PIN_ASSIGN_HIGH, 16'hffff);
    rd(OFS_CHIP_SELECT_PIN_ASSIGN_HIGH, 16'h03ff, "high ones");
    wr(OFS_PORT_C_OUTPUT_LATCH, 16'hffaa);
    rd(OFS_PORT_C_OUTPUT_LATCH, 16'h002a, "port mask");
    wr(8'h42, 16'hffff);
    rd(8'h42, 16'h0000, "unmapped");
    rd(OFS_CHIP_SELECT_PIN_ASSIGN_HIGH, 16'h03ff, "high kept");
    $display("test register access done");
    for (int m = 0; m < 4; m++)
    begin
      lo = {2'h0, {7{m[1:0]}}} | 16'h0002;
      hi = {6'h0, {5{m[1:0]}}};
      wr(OFS_CHIP_SELECT_PIN_ASSIGN_LOW, lo);
      wr(OFS_CHIP_SELECT_PIN_ASSIGN_HIGH, hi);
      wr(OFS_PORT_C_OUTPUT_LATCH, 16'h0055);
      src <= 8'h5a;
      cs_n <= 12'ha5a;
      pins(lo, hi, 16'h0055);
      src <= 8'ha5;
      cs_n <= 12'h5a5;
      wr(OFS_PORT_C_OUTPUT_LATCH, 16'h002a);
      pins(lo, hi, 16'h002a);
    end
    $display("test pin modes done");
    // all fields are wide selects now; pulse the pin 5 decode
    cs_n <= 12'hfff;
    repeat (3) @(posedge clk_in);
    c0 = cnt;
    cs_n[5] <= 1'b0;
    repeat (3) @(posedge clk_in);
    cs_n[5] <= 1'b1;
    repeat (3) @(posedge clk_in);
    chk("selected cycles", {8'h0, 8'h3}, {8'h0, cnt - c0});
    $display("test device select done");
    stop_test();
  end
endmodule : cspa_top_tb
